// [src/grx_block_receive.sv]
// Our own choices: the address map and strobed register access.
`timescale 1ns/100ps
`include "grx_map.svh"
module grx_block_receive (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire grx_pkg::grx_bus_req_s busReq,
  output grx_pkg::grx_bus_req_s busReqUnused,
  output logic [31:0] rdData,
  input wire logic listenAddressed,
  input wire grx_pkg::grx_byte_s rxByte,
  output logic rxReady,
  output grx_pkg::grx_mem_s memWr,
  output logic irqOut
);
  import grx_pkg::*;

  // ==========================================================
  // pin synchronisers
  // listen level, byte valid, byte data and eoi all come from the far side.
  // every one passes two stages, so data and valid arrive together:
  // the talker sets data with valid and holds it until valid drops,
  // hence the second data stage already holds the byte when valid shows.
  logic [1:0] lsnSync_reg;
  logic [1:0] vldSync_reg;
  logic [8:0] datSync1_reg;
  logic [8:0] datSync2_reg;
  logic [8:0] dataHold_reg;
  logic vldSeen_reg;
  // two-stage sampling of every far-side pin
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lsnSync_reg <= 2'h0;
      vldSync_reg <= 2'h0;
      datSync1_reg <= 9'h000;
      datSync2_reg <= 9'h000;
    end else begin
      lsnSync_reg <= {lsnSync_reg[0], listenAddressed};
      vldSync_reg <= {vldSync_reg[0], rxByte.valid};
      datSync1_reg <= {rxByte.eoi, rxByte.data};
      datSync2_reg <= datSync1_reg;
    end
  end
  // byte captured once per rising edge of the synchronised valid
  // a valid that stays high across a stall is never taken twice
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dataHold_reg <= 9'h000;
      vldSeen_reg <= 1'b0;
    end else begin
      vldSeen_reg <= vldSync_reg[1];
      if (vldSync_reg[1] && !vldSeen_reg) begin
        dataHold_reg <= datSync2_reg;
      end
    end
  end
  logic newByte;
  assign newByte = vldSync_reg[1] && !vldSeen_reg;

  // ==========================================================
  // registers
  logic [7:0] ctrl_reg;
  logic [15:0] seg_reg;
  logic [15:0] ofst_reg;
  logic [15:0] maxLen_reg;
  logic [15:0] rcvLen_reg;
  logic [7:0] stat_reg;
  logic [31:0] term_reg;
  logic [1:0] irqStat_reg;
  logic [1:0] irqEn_reg;
  logic [23:0] tmoLimit_reg;
  logic altMode_reg;
  grx_state_e state_reg;
  logic [23:0] tmoCnt_reg;
  logic [19:0] wrAddr_reg;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  logic startReq;
  assign startReq = busReq.wr && hit(busReq.addr, `GRX_OFS_CTRL + 8'h30) && busReq.wdata[`GRX_CMD_START_BIT];

  // software-written configuration
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      seg_reg <= 16'h0000;
      ofst_reg <= 16'h0000;
      maxLen_reg <= 16'h0000;
      term_reg <= `GRX_TERM_RST;
      irqEn_reg <= 2'h0;
      tmoLimit_reg <= `GRX_TMO_RST;
    end else if (busReq.wr) begin
      if (hit(busReq.addr, `GRX_OFS_SEG)) seg_reg <= busReq.wdata[15:0];
      if (hit(busReq.addr, `GRX_OFS_OFST)) ofst_reg <= busReq.wdata[15:0];
      if (hit(busReq.addr, `GRX_OFS_MAXLEN)) maxLen_reg <= busReq.wdata[15:0];
      if (hit(busReq.addr, `GRX_OFS_TERM)) term_reg <= busReq.wdata;
      if (hit(busReq.addr, `GRX_OFS_IRQ_EN)) irqEn_reg <= busReq.wdata[1:0];
      if (hit(busReq.addr, `GRX_OFS_TMO)) tmoLimit_reg <= busReq.wdata[23:0];
    end
  end

  // ==========================================================
  // terminator match
  // one comparator per table slot; the select field then picks a result.
  // the table is software-writable, so no slot value is built in here
  // beyond the reset defaults of the table register.
  // the alternate entry forces slot 0 and treats the terminator as enabled,
  // whatever the control byte holds in its enable and select fields.
  logic [3:0] slotHit;
  logic [1:0] termSel;
  logic termHit;
  genvar gSlot;
  generate
    for (gSlot = 0; gSlot < 4; gSlot++) begin : g_slot
      // compare held byte with one slot of the table
      assign slotHit[gSlot] = (dataHold_reg[7:0] == term_reg[8*gSlot +: 8]);
    end
  endgenerate
  // slot choice and enable gating
  always_comb begin
    termSel = ctrl_reg[`GRX_CTL_SEL_HI:`GRX_CTL_SEL_LO];
    if (altMode_reg) begin
      termSel = 2'b00;
    end
    termHit = (ctrl_reg[`GRX_CTL_TEN_BIT] || altMode_reg) && slotHit[termSel];
  end

  // ==========================================================
  // transfer engine
  // idle: control byte may be written, start launches a transfer.
  // wait: count idle cycles, accept the next synchronised byte.
  // write: store the held byte, bump count and address, judge the end.
  // done: one cycle with the final status, raises the done event.
  // end reasons, in priority order inside each state:
  //   wait: count already at maximum (covers a maximum of zero),
  //         then idle cycles reaching the timeout limit.
  //   write: eoi or enabled terminator on the stored byte (normal end),
  //          then the count reaching the maximum with this byte.
  // the ending byte is always stored and counted, never dropped.
  // a byte offered outside wait is not taken by the next wait: its valid
  // edge is seen only once, so a held valid does not offer it again.
  // timeout counts cycles between bytes, not the whole transfer.
  // hazard: a limit of zero ends a wait at once with the timeout flag.
  // status is written once, at the move into done, and then held
  // until the next move into done, so software may read it at leisure.
  // the same location takes the next control byte, which has a register
  // of its own and keeps its value, so software need not rewrite it.
  logic finish;
  logic [7:0] finStat;
  always_comb begin
    finish = 1'b0;
    finStat = 8'h00;
    if (state_reg == GRX_WAIT) begin
      if (rcvLen_reg >= maxLen_reg) begin
        finish = 1'b1;
      end else if (tmoCnt_reg >= tmoLimit_reg) begin
        finish = 1'b1;
        finStat[`GRX_ST_TIMEOUT_BIT] = 1'b1;
      end
    end else if (state_reg == GRX_WRITE) begin
      if (dataHold_reg[8] || termHit) begin
        finish = 1'b1;
        finStat[`GRX_ST_NORMAL_BIT] = 1'b1;
      end else if (rcvLen_reg + 16'h0001 >= maxLen_reg) begin
        finish = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= GRX_IDLE;
      ctrl_reg <= 8'h00;
      altMode_reg <= 1'b0;
      stat_reg <= 8'h00;
      rcvLen_reg <= 16'h0000;
      tmoCnt_reg <= 24'h000000;
      wrAddr_reg <= 20'h00000;
    end else begin
      unique case (state_reg)
        GRX_IDLE: begin
          if (busReq.wr && hit(busReq.addr, `GRX_OFS_STAT)) begin
            ctrl_reg <= busReq.wdata[7:0];
          end
          if (startReq) begin
            altMode_reg <= busReq.wdata[`GRX_CMD_ALT_BIT];
            rcvLen_reg <= 16'h0000;
            tmoCnt_reg <= 24'h000000;
            wrAddr_reg <= {seg_reg, 4'h0} + {4'h0, ofst_reg};
            if (!lsnSync_reg[1]) begin
              stat_reg <= 8'h02;
              state_reg <= GRX_DONE;
            end else begin
              state_reg <= GRX_WAIT;
            end
          end
        end
        GRX_WAIT: begin
          tmoCnt_reg <= tmoCnt_reg + 24'h000001;
          if (finish) begin
            stat_reg <= finStat;
            state_reg <= GRX_DONE;
          end else if (newByte) begin
            tmoCnt_reg <= 24'h000000;
            state_reg <= GRX_WRITE;
          end
        end
        GRX_WRITE: begin
          rcvLen_reg <= rcvLen_reg + 16'h0001;
          wrAddr_reg <= wrAddr_reg + 20'h00001;
          if (finish) begin
            stat_reg <= finStat;
            state_reg <= GRX_DONE;
          end else begin
            state_reg <= GRX_WAIT;
          end
        end
        GRX_DONE: begin
          state_reg <= GRX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // memory write port and byte acceptance
  // the store strobe follows the write state by one cycle, with the
  // address and byte that the write state saw; a single pulse each.
  // ready is withheld once an end is known, so the talker stops offering.
  // limitation: the memory side must take one byte per cycle, no stall.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      memWr <= '0;
      rxReady <= 1'b0;
    end else begin
      memWr.we <= (state_reg == GRX_WRITE);
      memWr.addr <= wrAddr_reg;
      memWr.data <= dataHold_reg[7:0];
      rxReady <= (state_reg == GRX_WAIT) && !finish;
    end
  end

  // ==========================================================
  // interrupts: done and error events, set wins over clear
  // bit 0 marks any completion, bit 1 a failed one (timeout or not
  // listening); a normal end alone never raises the error bit.
  // the output lags the sticky bits by one cycle, being a flip-flop.
  logic [1:0] irqSet;
  assign irqSet = {(state_reg == GRX_DONE) && (stat_reg[`GRX_ST_TIMEOUT_BIT] || stat_reg[`GRX_ST_NOTLSN_BIT]),
                   (state_reg == GRX_DONE)};
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStat_reg <= 2'h0;
      irqOut <= 1'b0;
    end else begin
      if (busReq.wr && hit(busReq.addr, `GRX_OFS_IRQ_CLR)) begin
        irqStat_reg <= (irqStat_reg & ~busReq.wdata[1:0]) | irqSet;
      end else begin
        irqStat_reg <= irqStat_reg | irqSet;
      end
      irqOut <= |(irqStat_reg & irqEn_reg);
    end
  end

  // ==========================================================
  // read port, data one cycle after strobe
  // read data is zero in every cycle without a read, so a stale value
  // can never be mistaken for an answer; unmapped offsets read zero.
  // offset zero reads busy and listening for polling software.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData <= 32'h00000000;
      busReqUnused <= '0;
    end else begin
      busReqUnused <= '0;
      rdData <= 32'h00000000;
      if (busReq.rd) begin
        unique case (busReq.addr)
          `GRX_OFS_SEG: rdData <= {16'h0000, seg_reg};
          `GRX_OFS_OFST: rdData <= {16'h0000, ofst_reg};
          `GRX_OFS_MAXLEN: rdData <= {16'h0000, maxLen_reg};
          `GRX_OFS_RCVLEN: rdData <= {16'h0000, rcvLen_reg};
          `GRX_OFS_STAT: rdData <= {24'h000000, stat_reg};
          `GRX_OFS_TERM: rdData <= term_reg;
          `GRX_OFS_IRQ_STAT: rdData <= {30'h00000000, irqStat_reg};
          `GRX_OFS_IRQ_EN: rdData <= {30'h00000000, irqEn_reg};
          `GRX_OFS_TMO: rdData <= {8'h00, tmoLimit_reg};
          `GRX_OFS_CTRL: rdData <= {30'h00000000, state_reg != GRX_IDLE, lsnSync_reg[1]};
          default: rdData <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // grx_block_receive

// [src/grx_map.svh]
`ifndef GRX_MAP_SVH
`define GRX_MAP_SVH
// ==========================================================
// register offsets (byte address, word index = byte address / 4)
`define GRX_OFS_CTRL 8'h00
`define GRX_OFS_SEG 8'h04
`define GRX_OFS_OFST 8'h08
`define GRX_OFS_MAXLEN 8'h0C
`define GRX_OFS_RCVLEN 8'h10
`define GRX_OFS_STAT 8'h14
`define GRX_OFS_TERM 8'h18
`define GRX_OFS_IRQ_STAT 8'h1C
`define GRX_OFS_IRQ_CLR 8'h20
`define GRX_OFS_IRQ_EN 8'h24
`define GRX_OFS_TMO 8'h28
// ==========================================================
// control byte fields
`define GRX_CTL_TEN_BIT 7
`define GRX_CTL_SEL_HI 6
`define GRX_CTL_SEL_LO 5
// command register bits
`define GRX_CMD_START_BIT 0
`define GRX_CMD_ALT_BIT 1
// ==========================================================
// status byte fields
`define GRX_ST_NORMAL_BIT 5
`define GRX_ST_TIMEOUT_BIT 3
`define GRX_ST_NOTLSN_BIT 1
// interrupt event bits
`define GRX_IRQ_DONE_BIT 0
`define GRX_IRQ_ERR_BIT 1
// ==========================================================
// reset values
`define GRX_TERM_RST 32'h3B2C0D0A
`define GRX_TMO_RST 24'h0F4240
`endif

// [src/grx_pkg.sv]
package grx_pkg;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    GRX_IDLE = 2'b00,
    GRX_WAIT = 2'b01,
    GRX_WRITE = 2'b10,
    GRX_DONE = 2'b11
  } grx_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } grx_bus_req_s;

  typedef struct packed {
    logic [7:0] data;
    logic eoi;
    logic valid;
  } grx_byte_s;

  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] data;
    logic we;
  } grx_mem_s;
endpackage

// [testbench/grx_block_receive_properties.sv]
`timescale 1ns/100ps
`include "grx_map.svh"
// ===
// port checker
module grx_rx_props (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire grx_pkg::grx_bus_req_s busReq,
  input wire logic [31:0] rdData,
  input wire logic listenAddressed,
  input wire grx_pkg::grx_byte_s rxByte,
  input wire logic rxReady,
  input wire grx_pkg::grx_mem_s memWr
);
  import grx_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic stRd;
  logic [2:0] readyAge;
  // status read in flight, cycles since waiting
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stRd <= 1'b0;
      readyAge <= 3'h7;
    end else begin
      stRd <= busReq.rd && busReq.addr == `GRX_OFS_STAT;
      readyAge <= rxReady ? 3'h0 : (readyAge == 3'h7 ? readyAge : readyAge + 3'h1);
    end
  end
  a_store_in_wait: assert property (memWr.we |-> readyAge < 3'h5)
    else $error("store outside a wait");
  a_byte_stored: assert property (rxReady && $rose(rxByte.valid) |-> ##[1:8] memWr.we)
    else $error("offered byte not stored");
  a_store_pulse: assert property (memWr.we |=> !memWr.we)
    else $error("store strobe too long");
  a_store_data: assert property (memWr.we |-> memWr.data == $past(rxByte.data, 2))
    else $error("stored byte differs");
  a_status_pad: assert property (stRd |-> rdData[7:6] == 2'h0 && !rdData[4] && !rdData[2] && !rdData[0])
    else $error("status pad bit set");
  a_normal_clean: assert property (stRd && rdData[5] |-> rdData[3:1] == 3'h0)
    else $error("normal end with fault");
  a_nolisten_idle: assert property (!listenAddressed [*8] |-> !$rose(rxReady))
    else $error("waiting while not listener");
  a_nolisten_nostore: assert property (!listenAddressed [*8] |-> !memWr.we)
    else $error("store while not listener");
  c_store: cover property (memWr.we);
  c_normal: cover property (stRd && rdData[5]);
  c_timeout: cover property (stRd && rdData[3]);
endmodule // grx_rx_props
bind grx_block_receive grx_rx_props i_props (.sys_clk(sys_clk), .rst_b(rst_b), .busReq(busReq),
  .rdData(rdData), .listenAddressed(listenAddressed), .rxByte(rxByte), .rxReady(rxReady), .memWr(memWr));

// [testbench/grx_talker_model.sv]
`timescale 1ns/100ps
// ===
// talker: 4-phase byte source
module grx_talker_model (
  input wire logic sys_clk,
  input wire logic rxReady,
  output grx_pkg::grx_byte_s rxByte
);
  import grx_pkg::*;
  logic [8:0] txQ[$]; // {eoi, data}
  int gap = 0; // idle cycles before a byte
  // offer one byte per wait, release after take
  initial begin
    rxByte = '{8'hA5, 1'b0, 1'b0};
    forever begin
      @(posedge sys_clk);
      if (rxReady && txQ.size() > 0) begin
        repeat (gap) @(posedge sys_clk);
        rxByte <= '{txQ[0][7:0], txQ[0][8], 1'b1};
        void'(txQ.pop_front());
        @(posedge sys_clk);
        while (rxReady) @(posedge sys_clk);
        rxByte.valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rxByte <= '{~rxByte.data, ~rxByte.eoi, 1'b0}; // released lines toggle
      end
    end
  end
endmodule // grx_talker_model

// [testbench/tb_grx_block_receive.sv]
`timescale 1ns/100ps
`include "grx_map.svh"
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin \
  mismatches++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_grx_block_receive;
  import grx_pkg::*;
  logic sysClk = 1'b0;
  logic rstB = 1'b0;
  logic listen = 1'b0;
  grx_bus_req_s busReq = '0;
  grx_bus_req_s spare;
  grx_byte_s rxByte;
  grx_mem_s memWr;
  logic [31:0] rdData;
  logic rxReady;
  logic irqOut;
  logic [27:0] memQ[$];
  int mismatches = 0;
  int samplesChecked = 0;
  // ===
  // clock, design, far side, store monitor
  always #25 sysClk = ~sysClk;
  grx_block_receive i_dut (.sys_clk(sysClk), .rst_b(rstB), .busReq(busReq), .busReqUnused(spare),
    .rdData(rdData), .listenAddressed(listen), .rxByte(rxByte), .rxReady(rxReady), .memWr(memWr), .irqOut(irqOut));
  grx_talker_model i_talk (.sys_clk(sysClk), .rxReady(rxReady), .rxByte(rxByte));
  always @(posedge sysClk) if (memWr.we) memQ.push_back({memWr.addr, memWr.data});
  // ===
  // bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge sysClk);
    busReq <= '0;
    @(posedge sysClk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    busReq <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sysClk);
    busReq <= '0;
    #1 d = rdData;
    @(posedge sysClk);
  endtask
  // one receive, judged on count, status and stores
  task automatic rcv(input logic [7:0] ctl, input logic [31:0] cmd, input logic [15:0] maxLen,
      input logic [8:0] tx[$], input logic [31:0] expCnt, input logic [7:0] expSt);
    logic [31:0] d;
    int n;
    memQ.delete();
    i_talk.txQ = tx;
    wr(`GRX_OFS_STAT, {24'h0, ctl});
    wr(`GRX_OFS_SEG, 32'h0123);
    wr(`GRX_OFS_OFST, 32'h0045);
    wr(`GRX_OFS_MAXLEN, {16'h0, maxLen});
    wr(8'h30, cmd);
    n = 0;
    do begin
      rd(`GRX_OFS_CTRL, d);
      n++;
    end while (d[1] && n < 400);
    `CHK("finished", 1'b0, d[1])
    rd(`GRX_OFS_RCVLEN, d);
    `CHK("count", expCnt, d)
    rd(`GRX_OFS_STAT, d);
    `CHK("status", expSt, d[7:0])
    `CHK("stores", expCnt, 32'(memQ.size()))
    for (int i = 0; i < expCnt; i++)
      `CHK("store", {20'h01275 + 20'(i), tx[i][7:0]}, memQ[i])
    i_talk.txQ.delete();
    i_talk.gap = 0;
  endtask
  task automatic chkIrq(input logic e);
    @(negedge sysClk);
    `CHK("irq", e, irqOut)
    @(posedge sysClk);
  endtask
  // ===
  // scenarios
  task automatic tTable();
    logic [31:0] d;
    rd(`GRX_OFS_TERM, d);
    `CHK("term table", 32'h3B2C0D0A, d)
    rd(8'hFC, d);
    `CHK("unmapped", 32'h0, d)
    `CHK("spare", '0, spare)
    wr(`GRX_OFS_TERM, 32'h3B210D0A);
    rcv(8'hC0, 32'h1, 16'h8, '{9'h02C, 9'h021}, 32'h2, 8'h20);
    wr(`GRX_OFS_TERM, 32'h3B2C0D0A);
  endtask
  task automatic tTerm();
    logic [7:0] ch[4] = '{8'h0A, 8'h0D, 8'h2C, 8'h3B};
    for (int s = 0; s < 4; s++)
      rcv({1'b1, 2'(s), 5'h1F}, 32'h1, 16'h8, '{9'h041, {1'b0, ch[(s + 1) % 4]}, {1'b0, ch[s]}, 9'h042},
        32'h3, 8'h20);
  endtask
  task automatic tOff();
    i_talk.gap = 20;
    rcv(8'h60, 32'h1, 16'h3, '{9'h03B, 9'h00A, 9'h041, 9'h042}, 32'h3, 8'h00);
  endtask
  task automatic tEoi();
    rcv(8'h00, 32'h1, 16'h8, '{9'h041, 9'h142, 9'h043}, 32'h2, 8'h20);
  endtask
  task automatic tIrq();
    logic [31:0] d;
    wr(`GRX_OFS_IRQ_CLR, 32'h3);
    tEoi();
    rd(`GRX_OFS_IRQ_STAT, d);
    `CHK("irq status", 32'h1, d)
    chkIrq(1'b0);
    wr(`GRX_OFS_IRQ_EN, 32'h3);
    chkIrq(1'b1);
    wr(`GRX_OFS_IRQ_CLR, 32'h1);
    chkIrq(1'b0);
  endtask
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ===
  // main sequence and watchdog
  initial begin
    repeat (16) @(posedge sysClk);
    rstB <= 1'b1;
    listen <= 1'b1;
    wr(`GRX_OFS_TMO, 32'h32);
    tTable();
    tTerm();
    tOff();
    tEoi();
    rcv(8'h80, 32'h1, 16'h8, '{9'h041}, 32'h1, 8'h08);
    rcv(8'h80, 32'h1, 16'h0, '{9'h00A}, 32'h0, 8'h00);
    rcv(8'h60, 32'h3, 16'h8, '{9'h041, 9'h03B, 9'h00A}, 32'h3, 8'h20);
    listen <= 1'b0;
    rcv(8'h80, 32'h1, 16'h8, '{9'h041}, 32'h0, 8'h02);
    listen <= 1'b1;
    tIrq();
    endOfTest();
  end
  initial begin
    #1000000;
    mismatches++;
    endOfTest();
  end
endmodule // tb_grx_block_receive
